// File: src/pioc_pkg.sv
// Constants shared by the pad I/O port control block
package pioc_pkg;

  // ***************************************************************
  // Register byte offsets, two words per 64-pad group, four for function select
  // ***************************************************************
  localparam logic [7:0] OFS_FSEL0     = 8'h00; // Pads 0-15
  localparam logic [7:0] OFS_FSEL1     = 8'h04; // Pads 16-31
  localparam logic [7:0] OFS_FSEL2     = 8'h08; // Pads 32-47
  localparam logic [7:0] OFS_FSEL3     = 8'h0C; // Pads 48-63
  localparam logic [7:0] OFS_DIR       = 8'h10;
  localparam logic [7:0] OFS_DIR_SET   = 8'h18;
  localparam logic [7:0] OFS_DIR_CLR   = 8'h20;
  localparam logic [7:0] OFS_DATA      = 8'h28;
  localparam logic [7:0] OFS_DATA_SET  = 8'h30;
  localparam logic [7:0] OFS_DATA_CLR  = 8'h38;
  localparam logic [7:0] OFS_PULL_EN   = 8'h40;
  localparam logic [7:0] OFS_PULL_SEL  = 8'h48;
  localparam logic [7:0] OFS_RD_SRC    = 8'h50;
  localparam logic [7:0] OFS_HYST      = 8'h58;
  localparam logic [7:0] OFS_KEEP      = 8'h60;
  localparam logic [7:0] OFS_PAD_LVL   = 8'h68; // Read-only levels

  // ***************************************************************
  // Function select codes
  // ***************************************************************
  localparam logic [1:0] FSEL_NORMAL = 2'h0;
  localparam logic [1:0] FSEL_ALT1   = 2'h1;
  localparam logic [1:0] FSEL_ALT2   = 2'h2;

  // ***************************************************************
  // Pad groups and reset values
  // ***************************************************************
  localparam logic [63:0] DEBUG_MASK  = 64'hFFFFC000_00000000;
  localparam logic [63:0] DBG_IN_MASK = 64'h8001C000_00000000;
  localparam logic [63:0] REF_MASK    = 64'h00000300_00000000;
  localparam logic [63:0] ANALOG_MASK = 64'h000003FF_C0000000;
  localparam logic [63:0] TWI_MASK    = 64'h00000000_00003000;
  localparam logic [63:0] SSI_MASK    = 64'h00000000_0000000F;
  localparam logic [63:0] RADIO_MASK  = 64'h00003C00_00000000;
  localparam logic [127:0] RST_FSEL   = 128'h0;
  localparam logic [63:0] RST_DIR     = 64'h0;
  localparam logic [63:0] RST_DATA    = 64'h0;
  localparam logic [63:0] RST_PULL_EN = 64'hFFFFFFFF_FFFFFFFF;
  localparam logic [63:0] RST_PULL_SEL = DBG_IN_MASK;
  localparam logic [63:0] RST_RD_SRC  = 64'h0;
  localparam logic [63:0] RST_HYST    = 64'h0;
  localparam logic [63:0] RST_KEEP    = 64'h0;

endpackage

// File: src/pioc_pad_mux.sv
// Per-pad steering between port control and peripherals
`timescale 1ns/1ps
module pioc_pad_mux
  import pioc_pkg::*;
(
  input  wire logic [127:0] fsel_in,
  input  wire logic [63:0]  dir_in,
  input  wire logic [63:0]  data_in,
  input  wire logic [63:0]  pull_en_in,
  input  wire logic [63:0]  pull_sel_in,
  input  wire logic [63:0]  hyst_in,
  input  wire logic [63:0]  keep_in,
  input  wire logic [63:0]  pad_lvl_in,
  input  wire logic [63:0]  per_out_in,
  input  wire logic [63:0]  per_oe_in,
  input  wire logic [63:0]  per_en_in,
  output logic      [63:0]  pad_out_out,
  output logic      [63:0]  pad_oe_out,
  output logic      [63:0]  pad_ie_out,
  output logic      [63:0]  pull_act_out,
  output logic      [63:0]  pull_up_out,
  output logic      [63:0]  hyst_out,
  output logic      [63:0]  keep_out,
  output logic      [63:0]  analog_out,
  output logic      [63:0]  per_in_out
);

  // Mode decision and pad drive for each pad
  always_comb begin
    logic [1:0] f;
    logic       per;
    f   = 2'h0;
    per = 1'b0;
    for (int i = 0; i < 64; i++) begin
      f = fsel_in[2*i +: 2];
      if (DEBUG_MASK[i] || REF_MASK[i]) begin
        per = (f == FSEL_NORMAL); // Dedicated function [R2] [R4]
      end else begin
        per = per_en_in[i] && ((f == FSEL_ALT1) ||
              (f == FSEL_ALT2 && RADIO_MASK[i])); // [R1] [R6]
      end
      // Port side settings always from registers [R11] [R12] [R13]
      hyst_out[i]    = hyst_in[i];
      keep_out[i]    = keep_in[i];
      pull_up_out[i] = pull_sel_in[i]; // [R9]
      analog_out[i]  = 1'b0;
      pad_ie_out[i]  = 1'b1;
      if (!per) begin
        pad_oe_out[i]  = dir_in[i]; // [R5] [R15]
        pad_out_out[i] = data_in[i]; // [R19]
        per_in_out[i]  = !SSI_MASK[i]; // [R23]
      end else if (ANALOG_MASK[i] &&
                   (REF_MASK[i] || !DEBUG_MASK[i])) begin
        pad_oe_out[i]  = 1'b0; // Digital pad off [R7]
        pad_out_out[i] = 1'b0;
        pad_ie_out[i]  = 1'b0;
        analog_out[i]  = 1'b1;
        per_in_out[i]  = 1'b0;
      end else if (TWI_MASK[i]) begin
        pad_oe_out[i]  = per_oe_in[i] && !per_out_in[i]; // [R24]
        pad_out_out[i] = 1'b0;
        per_in_out[i]  = pad_lvl_in[i];
      end else begin
        pad_oe_out[i]  = per_oe_in[i]; // [R8] [R18]
        pad_out_out[i] = per_out_in[i] && per_oe_in[i];
        per_in_out[i]  = pad_lvl_in[i];
      end
      // Resistor only while not driving [R10] [R24]
      pull_act_out[i] = pull_en_in[i] && !pad_oe_out[i] &&
                        !(per && TWI_MASK[i]);
    end
  end

endmodule

// File: src/pioc_port.sv
// Pad I/O port control registers with Avalon-MM slave
// Behaviour
// R1: Two-bit function select per pad; 00 normal, others alternates.
// R2: Reset puts all pads in function zero.
// R3: Ordinary pads leave reset as inputs with pull-down on.
// R4: Debug and reference pads use dedicated function zero; debug inputs pull up.
// R5: In port mode the port sets direction, output data and read source.
// R6: Function one hands ordinary pads to an enabled peripheral only.
// R7: Enabled converter turns its pads analog, digital pad off.
// R8: Peripheral gives output enable and drives data while enabled.
// R9: Per-pad resistor enable and up/down polarity bits.
// R10: Resistor active only when enabled and pad not driving.
// R11: Resistor, hysteresis, keeper always from port registers.
// R12: Per-pad hysteresis enable, off after reset.
// R13: Per-pad keeper enable, off after reset.
// R14: Direction registers read/write, default input.
// R15: Direction one is output, zero input.
// R16: Direction set alias: ones set bits, zeros leave bits.
// R17: Direction clear alias: ones clear bits, zeros leave bits.
// R18: Outside port mode direction comes from the peripheral.
// R19: Port output drives data bit; data resets to zero.
// R20: Data set alias: ones set bits, others unchanged.
// R21: Data clear alias: ones clear bits, others unchanged.
// R22: Read-source bit picks stored bit or pad level; resets to pad.
// R23: Port mode drives peripheral input high, low for audio port.
// R24: Two-wire pads: input and open-drain output, resistor off.
`timescale 1ns/1ps
module pioc_port
  import pioc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [3:0]        avs_byteenable_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Pads
  input  wire logic [63:0]       pad_in,
  output logic      [63:0]       pad_out,
  output logic      [63:0]       pad_oe_out,
  output logic      [63:0]       pad_ie_out,
  output logic      [63:0]       pull_en_out,
  output logic      [63:0]       pull_up_out,
  output logic      [63:0]       hyst_en_out,
  output logic      [63:0]       keep_en_out,
  output logic      [63:0]       analog_en_out,
  // Peripherals
  input  wire logic [63:0]       per_out_in,
  input  wire logic [63:0]       per_oe_in,
  input  wire logic [63:0]       per_en_in,
  output logic      [63:0]       per_in_out
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [127:0] fsel;
    logic [63:0]  dir;
    logic [63:0]  data;
    logic [63:0]  pull_en;
    logic [63:0]  pull_sel;
    logic [63:0]  rd_src;
    logic [63:0]  hyst;
    logic [63:0]  keep;
    logic [63:0]  pad_lvl;
    logic         ack;
    logic [31:0]  rdata;
    logic [63:0]  o_out;
    logic [63:0]  o_oe;
    logic [63:0]  o_ie;
    logic [63:0]  o_pull;
    logic [63:0]  o_up;
    logic [63:0]  o_hyst;
    logic [63:0]  o_keep;
    logic [63:0]  o_ana;
    logic [63:0]  o_per;
  } pioc_state_t;

  pioc_state_t s_q;
  pioc_state_t s_d;

  // Combinational pad decisions
  logic [63:0] m_out;
  logic [63:0] m_oe;
  logic [63:0] m_ie;
  logic [63:0] m_pull;
  logic [63:0] m_up;
  logic [63:0] m_hyst;
  logic [63:0] m_keep;
  logic [63:0] m_ana;
  logic [63:0] m_per;

  // ***************************************************************
  // Helper functions
  // ***************************************************************

  // Byte-lane mask from byte enables
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Hit when an address matches either word of a 64-bit pair
  function automatic logic pair_hit(input logic [7:0] a,
                                    input logic [7:0] base);
    pair_hit = (a == base) || (a == base + 8'h04);
  endfunction

  // Write one word of a 64-bit register
  function automatic logic [63:0] wr_pair(input logic [63:0] r,
                                          input logic        hi,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
    logic [63:0] v;
    v = r;
    if (hi) begin
      v[63:32] = (r[63:32] & ~m) | (wd & m);
    end else begin
      v[31:0] = (r[31:0] & ~m) | (wd & m);
    end
    wr_pair = v;
  endfunction

  // Set or clear bits under a one-mask
  function automatic logic [63:0] sc_pair(input logic [63:0] r,
                                          input logic        hi,
                                          input logic [31:0] ones,
                                          input logic        set);
    logic [63:0] m;
    m = hi ? {ones, 32'h0} : {32'h0, ones};
    sc_pair = set ? (r | m) : (r & ~m);
  endfunction

  // Select one word of a 64-bit register
  function automatic logic [31:0] rd_pair(input logic [63:0] r,
                                          input logic        hi);
    rd_pair = hi ? r[63:32] : r[31:0];
  endfunction

  // ***************************************************************
  // Pad steering
  // ***************************************************************
  pioc_pad_mux u_mux (
    .fsel_in     (s_q.fsel),
    .dir_in      (s_q.dir),
    .data_in     (s_q.data),
    .pull_en_in  (s_q.pull_en),
    .pull_sel_in (s_q.pull_sel),
    .hyst_in     (s_q.hyst),
    .keep_in     (s_q.keep),
    .pad_lvl_in  (s_q.pad_lvl),
    .per_out_in  (per_out_in),
    .per_oe_in   (per_oe_in),
    .per_en_in   (per_en_in),
    .pad_out_out (m_out),
    .pad_oe_out  (m_oe),
    .pad_ie_out  (m_ie),
    .pull_act_out(m_pull),
    .pull_up_out (m_up),
    .hyst_out    (m_hyst),
    .keep_out    (m_keep),
    .analog_out  (m_ana),
    .per_in_out  (m_per)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic [7:0]  a;
    logic        hi;
    logic        req;
    logic [31:0] m;
    logic [31:0] wd;
    logic [31:0] rv;
    a   = 8'(avs_address_in);
    hi  = a[2];
    req = avs_read_in || avs_write_in;
    m   = lane_mask(avs_byteenable_in);
    wd  = avs_writedata_in;
    rv  = 32'h0;
    s_d = s_q;

    // Pad level sampling register
    s_d.pad_lvl = pad_in;

    // One wait cycle, then complete
    s_d.ack = req && !s_q.ack;

    // Read data captured in the wait cycle
    if (a == OFS_FSEL0) begin
      rv = s_q.fsel[31:0];
    end else if (a == OFS_FSEL1) begin
      rv = s_q.fsel[63:32];
    end else if (a == OFS_FSEL2) begin
      rv = s_q.fsel[95:64];
    end else if (a == OFS_FSEL3) begin
      rv = s_q.fsel[127:96];
    end else if (pair_hit(a, OFS_DIR)) begin
      rv = rd_pair(s_q.dir, hi); // [R14]
    end else if (pair_hit(a, OFS_DATA)) begin
      // Stored bit or pad level per pad [R22]
      rv = rd_pair((s_q.rd_src & s_q.data) |
                   (~s_q.rd_src & s_q.pad_lvl), hi);
    end else if (pair_hit(a, OFS_PULL_EN)) begin
      rv = rd_pair(s_q.pull_en, hi);
    end else if (pair_hit(a, OFS_PULL_SEL)) begin
      rv = rd_pair(s_q.pull_sel, hi);
    end else if (pair_hit(a, OFS_RD_SRC)) begin
      rv = rd_pair(s_q.rd_src, hi);
    end else if (pair_hit(a, OFS_HYST)) begin
      rv = rd_pair(s_q.hyst, hi);
    end else if (pair_hit(a, OFS_KEEP)) begin
      rv = rd_pair(s_q.keep, hi);
    end else if (pair_hit(a, OFS_PAD_LVL)) begin
      rv = rd_pair(s_q.pad_lvl, hi);
    end else begin
      rv = 32'h0; // Unmapped and write-only read as zero
    end
    if (avs_read_in && !s_q.ack) begin
      s_d.rdata = rv;
    end

    // Writes take effect on the completing edge
    if (avs_write_in && s_q.ack) begin
      if (a == OFS_FSEL0) begin
        s_d.fsel[31:0] = (s_q.fsel[31:0] & ~m) | (wd & m); // [R1]
      end else if (a == OFS_FSEL1) begin
        s_d.fsel[63:32] = (s_q.fsel[63:32] & ~m) | (wd & m);
      end else if (a == OFS_FSEL2) begin
        s_d.fsel[95:64] = (s_q.fsel[95:64] & ~m) | (wd & m);
      end else if (a == OFS_FSEL3) begin
        s_d.fsel[127:96] = (s_q.fsel[127:96] & ~m) | (wd & m);
      end else if (pair_hit(a, OFS_DIR)) begin
        s_d.dir = wr_pair(s_q.dir, hi, wd, m); // [R14]
      end else if (pair_hit(a, OFS_DIR_SET)) begin
        s_d.dir = sc_pair(s_q.dir, hi, wd & m, 1'b1); // [R16]
      end else if (pair_hit(a, OFS_DIR_CLR)) begin
        s_d.dir = sc_pair(s_q.dir, hi, wd & m, 1'b0); // [R17]
      end else if (pair_hit(a, OFS_DATA)) begin
        s_d.data = wr_pair(s_q.data, hi, wd, m);
      end else if (pair_hit(a, OFS_DATA_SET)) begin
        s_d.data = sc_pair(s_q.data, hi, wd & m, 1'b1); // [R20]
      end else if (pair_hit(a, OFS_DATA_CLR)) begin
        s_d.data = sc_pair(s_q.data, hi, wd & m, 1'b0); // [R21]
      end else if (pair_hit(a, OFS_PULL_EN)) begin
        s_d.pull_en = wr_pair(s_q.pull_en, hi, wd, m); // [R9]
      end else if (pair_hit(a, OFS_PULL_SEL)) begin
        s_d.pull_sel = wr_pair(s_q.pull_sel, hi, wd, m); // [R9]
      end else if (pair_hit(a, OFS_RD_SRC)) begin
        s_d.rd_src = wr_pair(s_q.rd_src, hi, wd, m); // [R22]
      end else if (pair_hit(a, OFS_HYST)) begin
        s_d.hyst = wr_pair(s_q.hyst, hi, wd, m); // [R12]
      end else if (pair_hit(a, OFS_KEEP)) begin
        s_d.keep = wr_pair(s_q.keep, hi, wd, m); // [R13]
      end
    end

    // Registered pad and peripheral outputs
    s_d.o_out  = m_out;
    s_d.o_oe   = m_oe;
    s_d.o_ie   = m_ie;
    s_d.o_pull = m_pull;
    s_d.o_up   = m_up;
    s_d.o_hyst = m_hyst;
    s_d.o_keep = m_keep;
    s_d.o_ana  = m_ana;
    s_d.o_per  = m_per;
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q.fsel     <= RST_FSEL; // [R2]
      s_q.dir      <= RST_DIR; // [R3] [R14]
      s_q.data     <= RST_DATA; // [R19]
      s_q.pull_en  <= RST_PULL_EN; // [R3]
      s_q.pull_sel <= RST_PULL_SEL; // [R4]
      s_q.rd_src   <= RST_RD_SRC; // [R22]
      s_q.hyst     <= RST_HYST; // [R12]
      s_q.keep     <= RST_KEEP; // [R13]
      s_q.pad_lvl  <= 64'h0;
      s_q.ack      <= 1'b0;
      s_q.rdata    <= 32'h0;
      s_q.o_out    <= 64'h0;
      s_q.o_oe     <= 64'h0;
      s_q.o_ie     <= 64'hFFFFFFFF_FFFFFFFF;
      s_q.o_pull   <= RST_PULL_EN;
      s_q.o_up     <= RST_PULL_SEL;
      s_q.o_hyst   <= RST_HYST;
      s_q.o_keep   <= RST_KEEP;
      s_q.o_ana    <= 64'h0;
      s_q.o_per    <= ~SSI_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) &&
                               !s_q.ack;
  assign avs_readdata_out    = s_q.rdata;
  assign pad_out             = s_q.o_out;
  assign pad_oe_out          = s_q.o_oe;
  assign pad_ie_out          = s_q.o_ie;
  assign pull_en_out         = s_q.o_pull;
  assign pull_up_out         = s_q.o_up;
  assign hyst_en_out         = s_q.o_hyst;
  assign keep_en_out         = s_q.o_keep;
  assign analog_en_out       = s_q.o_ana;
  assign per_in_out          = s_q.o_per;

endmodule

// File: dv/pioc_far_model.sv
// Pad-side model: resolves each pad level seen by the port
`timescale 1ns/1ps
module pioc_far_model
  import pioc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic [63:0] pad_out_in,
  input  wire logic [63:0] pad_oe_in,
  input  wire logic [63:0] pull_en_in,
  input  wire logic [63:0] pull_up_in,
  input  wire logic [63:0] keep_en_in,
  output logic      [63:0] pad_lvl_out
);
  logic [63:0] last_q = 64'h0;

  // Drive wins, then resistor, then board pull-up on two-wire pads, then keeper; a floating pad toggles
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pad_oe_in[i]) pad_lvl_out[i] = pad_out_in[i];
      else if (pull_en_in[i]) pad_lvl_out[i] = pull_up_in[i];
      else if (TWI_MASK[i]) pad_lvl_out[i] = 1'b1; // Board pull-up
      else if (keep_en_in[i]) pad_lvl_out[i] = last_q[i];
      else pad_lvl_out[i] = ~last_q[i];
    end
  end

  // Last level, for keeper and floating pads
  always_ff @(posedge ref_clk_in) begin
    last_q <= pad_lvl_out;
  end
endmodule

// File: dv/pioc_port_sva.sv
// Concurrent checks on the pad I/O port control pins
`timescale 1ns/1ps
module pioc_sva
  import pioc_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [63:0] pad_oe_out,
  input wire logic [63:0] pad_ie_out,
  input wire logic [63:0] pull_en_out,
  input wire logic [63:0] pull_up_out,
  input wire logic [63:0] hyst_en_out,
  input wire logic [63:0] keep_en_out,
  input wire logic [63:0] analog_en_out,
  input wire logic [63:0] per_en_in,
  input wire logic [63:0] per_in_out
);
  // ***************************************************************
  // Pin relations
  // ***************************************************************
  localparam logic [63:0] ORD = ~(DEBUG_MASK | REF_MASK);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_rst_dir;
    $rose(nrst_in) |-> (pad_oe_out & ORD) == 64'h0 &&
      pull_en_out == 64'hFFFFFFFF_FFFFFFFF;
  endproperty
  a_rst_dir: assert property (p_rst_dir)
    else $error("pads not inputs with resistor after reset");
  property p_rst_up;
    $rose(nrst_in) |-> pull_up_out == DBG_IN_MASK;
  endproperty
  a_rst_up: assert property (p_rst_up)
    else $error("resistor polarity wrong after reset");
  property p_rst_hyst;
    $rose(nrst_in) |-> hyst_en_out == 64'h0;
  endproperty
  a_rst_hyst: assert property (p_rst_hyst)
    else $error("hysteresis on after reset");
  property p_rst_keep;
    $rose(nrst_in) |-> keep_en_out == 64'h0;
  endproperty
  a_rst_keep: assert property (p_rst_keep)
    else $error("keeper on after reset");
  property p_pull_drv;
    (pull_en_out & pad_oe_out) == 64'h0;
  endproperty
  a_pull_drv: assert property (p_pull_drv)
    else $error("resistor active on a driving pad");
  property p_analog_off;
    (analog_en_out & (pad_oe_out | pad_ie_out)) == 64'h0;
  endproperty
  a_analog_off: assert property (p_analog_off)
    else $error("digital path on in analog mode");
  property p_analog_pads;
    (analog_en_out & ~ANALOG_MASK) == 64'h0;
  endproperty
  a_analog_pads: assert property (p_analog_pads)
    else $error("analog mode on a digital-only pad");
  property p_port_per_in;
    1'b1 |=> ((per_in_out ^ ~SSI_MASK) & ORD & ~$past(per_en_in)) == 64'h0;
  endproperty
  a_port_per_in: assert property (p_port_per_in)
    else $error("peripheral input not at idle level in port mode");
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("register access wait not one cycle");
  property p_rd_hold;
    !avs_read_in |=> $stable(avs_readdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

  c_analog: cover property (analog_en_out != 64'h0);
  c_per_drive: cover property ((pad_oe_out & per_en_in) != 64'h0);
  c_write: cover property (avs_write_in && !avs_waitrequest_out);
endmodule

bind pioc_port pioc_sva u_sva (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .pad_oe_out(pad_oe_out),
  .pad_ie_out(pad_ie_out), .pull_en_out(pull_en_out),
  .pull_up_out(pull_up_out), .hyst_en_out(hyst_en_out),
  .keep_en_out(keep_en_out), .analog_en_out(analog_en_out),
  .per_en_in(per_en_in), .per_in_out(per_in_out)
);

// File: dv/pad_io_port_control_tb.sv
// Self-checking bench for the pad I/O port control block
`timescale 1ns/1ps
module pad_io_port_control_tb
  import pioc_pkg::*;
;
  typedef struct {
    logic wr; logic [7:0] wa; logic [31:0] wd; logic [7:0] ra;
    logic [31:0] ex;
  } pioc_row_t;
  logic        ref_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, rd;
  logic        avs_waitrequest_out;
  logic [63:0] pad_in, pad_out, pad_oe_out, pad_ie_out, pull_en_out;
  logic [63:0] pull_up_out, hyst_en_out, keep_en_out, analog_en_out;
  logic [63:0] per_out_in = 64'h0, per_oe_in = 64'h0, per_en_in = 64'h0;
  logic [63:0] per_in_out;
  int          n_errors = 0, check_count = 0;
  pioc_row_t   rows [22] = '{
    '{0, 8'h00, 32'h0, 8'h10, 32'h0}, '{0, 8'h00, 32'h0, 8'h44, 32'hFFFFFFFF},
    '{0, 8'h00, 32'h0, 8'h4C, 32'h8001C000}, // Debug inputs pulled up
    '{0, 8'h00, 32'h0, 8'h5C, 32'h0}, '{0, 8'h00, 32'h0, 8'h60, 32'h0},
    '{0, 8'h00, 32'h0, 8'h0C, 32'h0}, '{0, 8'h00, 32'h0, 8'h54, 32'h0},
    '{0, 8'h00, 32'h0, 8'h28, 32'h0}, // Pads pulled down
    '{1, 8'h50, 32'hFFFFFFFF, 8'h50, 32'hFFFFFFFF},
    '{1, 8'h10, 32'h0000F0F0, 8'h10, 32'h0000F0F0},
    '{1, 8'h18, 32'h00000F01, 8'h10, 32'h0000FFF1},
    '{1, 8'h20, 32'h000000F0, 8'h10, 32'h0000FF01},
    '{1, 8'h28, 32'h0000A5A5, 8'h28, 32'h0000A5A5},
    '{1, 8'h30, 32'h00000A0A, 8'h28, 32'h0000AFAF},
    '{1, 8'h38, 32'h0000000F, 8'h28, 32'h0000AFA0},
    '{0, 8'h00, 32'h0, 8'h30, 32'h0}, // Write-only alias
    '{1, 8'h58, 32'h12345678, 8'h58, 32'h12345678},
    '{1, 8'h64, 32'h0F0F0000, 8'h64, 32'h0F0F0000},
    '{1, 8'h48, 32'h0000FFFF, 8'h48, 32'h0000FFFF},
    '{1, 8'h70, 32'hFFFFFFFF, 8'h70, 32'h0}, // Unmapped
    '{0, 8'h00, 32'h0, 8'h2C, 32'h8001C000}, // Pad levels by pulls
    '{0, 8'h00, 32'h0, 8'h68, 32'h0000AFFE}}; // Driven, pulled pads

  pioc_port uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe_out), .pad_ie_out(pad_ie_out),
    .pull_en_out(pull_en_out), .pull_up_out(pull_up_out),
    .hyst_en_out(hyst_en_out), .keep_en_out(keep_en_out),
    .analog_en_out(analog_en_out), .per_out_in(per_out_in),
    .per_oe_in(per_oe_in), .per_en_in(per_en_in), .per_in_out(per_in_out));
  pioc_far_model far (
    .ref_clk_in(ref_clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
    .pull_en_in(pull_en_out), .pull_up_in(pull_up_out),
    .keep_en_in(keep_en_out), .pad_lvl_out(pad_in));

  // ***************************************************************
  // Clock, tasks and sequence
  // ***************************************************************
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer, held until a rising edge sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  // Watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      if (rows[i].wr) bus(1'b1, rows[i].wa, rows[i].wd, 4'hF, rd);
      bus(1'b0, rows[i].ra, 32'h0, 4'hF, rd);
      chk({32'h0, rd}, {32'h0, rows[i].ex});
    end
    chk({pad_oe_out[31:0], pad_out[31:0] & pad_oe_out[31:0]},
        64'h0000FF01_0000AF00);
    chk({hyst_en_out[31:0], keep_en_out[63:32]},
        64'h12345678_0F0F0000);
    chk({32'h0, pull_up_out[31:0]}, 64'h0000FFFF);
    $display("register table done");
    bus(1'b1, 8'h00, 32'h01000104, 4'hF, rd);
    bus(1'b1, 8'h04, 32'h10000000, 4'hF, rd);
    repeat (3) @(posedge ref_clk_in);
    chk({59'h0, pad_oe_out[4], per_in_out[4], per_in_out[1], pad_oe_out[12],
         analog_en_out[30]}, 64'h0A);
    per_en_in <= 64'h40001010;
    per_oe_in <= 64'h1010;
    per_out_in <= 64'h10;
    repeat (3) @(posedge ref_clk_in);
    chk({54'h0, pad_oe_out[4], pad_out[4], pull_en_out[4], analog_en_out[30],
         pad_ie_out[30], pad_oe_out[30], pad_oe_out[12], pad_out[12],
         pull_en_out[12], pad_ie_out[12]}, 64'h349);
    per_oe_in <= 64'h1000;
    per_out_in <= 64'h1000;
    repeat (4) @(posedge ref_clk_in);
    chk({58'h0, pad_oe_out[4], pull_en_out[4], per_in_out[4], pad_oe_out[12],
         pull_en_out[12], pad_ie_out[12]}, 64'h19);
    // Radio control pad in its second alternate function
    bus(1'b1, 8'h08, 32'h02000000, 4'hF, rd);
    per_en_in <= 64'h00001000_40001010;
    per_oe_in <= 64'h00001000_00001000;
    per_out_in <= 64'h00001000_00001000;
    repeat (3) @(posedge ref_clk_in);
    chk({62'h0, pad_oe_out[44], pad_out[44]}, 64'h3);
    $display("peripheral modes done");
    nrst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    bus(1'b0, 8'h10, 32'h0, 4'hF, rd);
    chk({32'h0, rd}, 64'h0);
    chk(pad_oe_out & ~(DEBUG_MASK | REF_MASK), 64'h0);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, 4'h2, rd);
    bus(1'b0, 8'h10, 32'h0, 4'hF, rd);
    chk({32'h0, rd}, 64'h0000FF00);
    $display("mid-run reset done");
    test_done();
  end
endmodule
